// [include/par_pkg.sv]
// Package with register map, field positions and reset values of the ability registers
package par_pkg;
  // Number of copper ports and the address nibble of the first one
  localparam int          NPORT          = 5;
  localparam logic [3:0]  PORT_FIRST     = 4'h1;
  localparam logic [3:0]  PORT_LAST      = 4'h5;
  // Per-port register offsets (low twelve address bits)
  localparam logic [11:0] OFS_BASIC_CTRL = 12'h100;
  localparam logic [11:0] OFS_BASIC_STAT = 12'h102;
  localparam logic [11:0] OFS_ADVERT     = 12'h108;
  localparam logic [11:0] OFS_PARTNER    = 12'h10a;
  localparam logic [11:0] OFS_EXPANSION  = 12'h10c;
  // Interrupt registers, full sixteen-bit addresses
  localparam logic [15:0] ADDR_IRQ_STAT  = 16'h0f00;
  localparam logic [15:0] ADDR_IRQ_MASK  = 16'h0f02;
  // Field positions
  localparam int          BIT_NEXT_PAGE  = 15;
  localparam int          BIT_ACK        = 14;
  localparam int          BIT_RFAULT     = 13;
  localparam int          BIT_T4         = 9;
  localparam int          BIT_RESTART    = 9;
  localparam int          BIT_AN_DONE    = 5;
  localparam int          EXP_PD_FAULT   = 4;
  localparam int          EXP_LP_NP_ABLE = 3;
  localparam int          EXP_NP_ABLE    = 2;
  localparam int          EXP_PAGE_RX    = 1;
  localparam int          EXP_LP_AN_ABLE = 0;
  // Advertisement: reset value and writable bits (15, 13, 11:10, 8:5, 4:0)
  localparam logic [15:0] ADVERT_RESET   = 16'h05e1;
  localparam logic [15:0] ADVERT_WMASK   = 16'hadff;
  // Partner word bits captured from the code word (not 14, not 12)
  localparam logic [15:0] PARTNER_CMASK  = 16'hafff;
  // Interrupt word: two events per port
  localparam int          IRQ_W          = 2 * NPORT;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 10'h000;
endpackage

// [include/par_irq_if.sv]
// Interface between the register bank and its interrupt controller
`timescale 1ns/1ns
`default_nettype none
interface par_irq_if;
  import par_pkg::*;
  logic [IRQ_W-1:0] events;
  logic             wr_stat;
  logic             wr_mask;
  logic [IRQ_W-1:0] wdata;
  logic [IRQ_W-1:0] stat;
  logic [IRQ_W-1:0] mask;
  logic             irq;
  modport ctrl (input events, wr_stat, wr_mask, wdata, output stat, mask, irq);
  modport host (output events, wr_stat, wr_mask, wdata, input stat, mask, irq);
endinterface
`default_nettype wire

// [src/par_latch_flag.sv]
// Latched-high flag that clears on read unless its cause persists
`timescale 1ns/1ns
`default_nettype none
module par_latch_flag (
  input  wire logic i_sys_clk,
  input  wire logic i_srst,
  input  wire logic i_set,
  input  wire logic i_clr,
  output logic      o_flag
);
  logic flag_reg;
  logic flag_next;

  // Set wins over the read clear
  assign flag_next = i_set | (flag_reg & ~i_clr);

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign o_flag = flag_reg;
endmodule
`default_nettype wire

// [src/par_irq_ctrl.sv]
// Sticky interrupt status, mask and level interrupt output
`timescale 1ns/1ns
`default_nettype none
module par_irq_ctrl (
  input  wire logic  i_sys_clk,
  input  wire logic  i_srst,
  par_irq_if.ctrl    bus
);
  import par_pkg::*;

  logic [IRQ_W-1:0] stat_reg;
  logic [IRQ_W-1:0] stat_next;
  logic [IRQ_W-1:0] mask_reg;
  logic [IRQ_W-1:0] mask_next;
  logic             irq_reg;
  logic [IRQ_W-1:0] w1c;

  // Write one to clear; a new event in the same cycle stays set
  assign w1c       = bus.wr_stat ? bus.wdata : IRQ_RESET;
  assign stat_next = (stat_reg & ~w1c) | bus.events;
  assign mask_next = bus.wr_mask ? bus.wdata : mask_reg;

  // Status, mask and registered interrupt level
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      stat_reg <= IRQ_RESET;
      mask_reg <= IRQ_RESET;
      irq_reg  <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      irq_reg  <= |(stat_reg & mask_reg);
    end
  end

  assign bus.stat = stat_reg;
  assign bus.mask = mask_reg;
  assign bus.irq  = irq_reg;
endmodule
`default_nettype wire

// [src/par_ability_regs.sv]
// Auto-negotiation ability registers of the five copper ports
//
// Overview of operation
// - Advertise next page bit, writable, reset zero
// - Advertise remote fault bit, writable, reset zero
// - Pause field bits 11:10 writable, reset 01
// - T4 advertisement bit always reads zero
// - Speed and duplex bits writable, reset one
// - Partner word read-only, filled from code word
// - Partner acknowledge bit set once word received
// - Partner remote fault bit from received page
// - Parallel detection fault latched high
// - Expansion bit 3 mirrors partner next page
// - Expansion bit 2 always reads one
// - Page received flag latched high
// - Expansion bit 0 shows partner negotiation ability
// - Basic status bit 5 shows negotiation done
`timescale 1ns/1ns
`default_nettype none
module par_ability_regs (
  input  wire logic                           i_sys_clk,
  input  wire logic                           i_srst,
  input  wire logic [15:0]                    i_addr,
  input  wire logic [15:0]                    i_wdata,
  input  wire logic                           i_wr,
  input  wire logic                           i_rd,
  input  wire logic [par_pkg::NPORT-1:0]      i_lcw_valid,
  input  wire logic [par_pkg::NPORT*16-1:0]   i_lcw_data,
  input  wire logic [par_pkg::NPORT-1:0]      i_lp_an_able,
  input  wire logic [par_pkg::NPORT-1:0]      i_pd_fault,
  input  wire logic [par_pkg::NPORT-1:0]      i_an_done,
  output logic      [15:0]                    o_rdata,
  output logic                                o_irq,
  output logic      [par_pkg::NPORT-1:0]      o_restart_an,
  output logic      [par_pkg::NPORT*16-1:0]   o_adv_word
);
  import par_pkg::*;

  // Address split into port nibble and register offset
  logic [3:0]  port_sel;
  logic [11:0] reg_ofs;
  assign port_sel = i_addr[15:12];
  assign reg_ofs  = i_addr[11:0];

  // Interrupt register decode
  logic hit_irq_stat;
  logic hit_irq_mask;
  assign hit_irq_stat = (i_addr == ADDR_IRQ_STAT);
  assign hit_irq_mask = (i_addr == ADDR_IRQ_MASK);

  // Per-port read words, chained into one bus value
  logic [15:0] port_rd   [NPORT];
  logic [15:0] rd_chain  [NPORT+1];
  logic        port_hit  [NPORT];
  logic        hit_chain [NPORT+1];

  assign rd_chain[0]  = 16'h0000;
  assign hit_chain[0] = 1'b0;

  // Interrupt controller link
  par_irq_if irq_bus ();

  genvar p;
  generate
    for (p = 0; p < NPORT; p++) begin : g_port
      // Selection of this port by the address nibble
      logic sel;
      logic wr_ctrl;
      logic wr_adv;
      logic rd_exp;
      logic hit_ctrl;
      logic hit_stat;
      logic hit_adv;
      logic hit_lp;
      logic hit_exp;
      assign sel      = (port_sel == 4'(p + 1));
      assign hit_ctrl = sel & (reg_ofs == OFS_BASIC_CTRL);
      assign hit_stat = sel & (reg_ofs == OFS_BASIC_STAT);
      assign hit_adv  = sel & (reg_ofs == OFS_ADVERT);
      assign hit_lp   = sel & (reg_ofs == OFS_PARTNER);
      assign hit_exp  = sel & (reg_ofs == OFS_EXPANSION);
      assign wr_ctrl  = i_wr & hit_ctrl;
      assign wr_adv   = i_wr & hit_adv;
      assign rd_exp   = i_rd & hit_exp;

      // Received code word of this port
      logic [15:0] lcw;
      assign lcw = i_lcw_data[p*16 +: 16];

      // Local advertisement with writable fields only
      logic [15:0] adv_reg;
      logic [15:0] adv_next;
      assign adv_next = wr_adv ? (i_wdata & ADVERT_WMASK) : adv_reg;

      // Restart pulse, one cycle per write of the restart bit
      logic restart_reg;
      logic restart_next;
      assign restart_next = wr_ctrl & i_wdata[BIT_RESTART];

      // Partner word and its received marker
      logic [15:0] lp_reg;
      logic [15:0] lp_next;
      logic        rx_seen_reg;
      logic        rx_seen_next;
      assign lp_next      = i_lcw_valid[p] ? (lcw & PARTNER_CMASK) : lp_reg;
      assign rx_seen_next = i_lcw_valid[p] | (rx_seen_reg & ~restart_reg);

      // Sampled partner ability and completion levels
      logic lp_an_reg;
      logic an_done_reg;

      // Register update for this port
      always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
          adv_reg     <= ADVERT_RESET;
          restart_reg <= 1'b0;
          lp_reg      <= 16'h0000;
          rx_seen_reg <= 1'b0;
          lp_an_reg   <= 1'b0;
          an_done_reg <= 1'b0;
        end else begin
          adv_reg     <= adv_next;
          restart_reg <= restart_next;
          lp_reg      <= lp_next;
          rx_seen_reg <= rx_seen_next;
          lp_an_reg   <= i_lp_an_able[p];
          an_done_reg <= i_an_done[p];
        end
      end

      // Latched-high expansion flags, cleared by reading expansion
      logic page_flag;
      logic pdf_flag;
      par_latch_flag u_page (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_set     (i_lcw_valid[p]),
        .i_clr     (rd_exp),
        .o_flag    (page_flag)
      );
      par_latch_flag u_pdf (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_set     (i_pd_fault[p]),
        .i_clr     (rd_exp),
        .o_flag    (pdf_flag)
      );

      // Read views of the three ability words and basic status
      logic [15:0] adv_view;
      logic [15:0] lp_view;
      logic [15:0] exp_view;
      logic [15:0] stat_view;
      assign adv_view = adv_reg & ~(16'h0001 << BIT_T4);
      assign lp_view  = lp_reg | (16'(rx_seen_reg) << BIT_ACK);
      assign exp_view = (16'(pdf_flag) << EXP_PD_FAULT)
                      | (16'(lp_reg[BIT_NEXT_PAGE]) << EXP_LP_NP_ABLE)
                      | (16'h0001 << EXP_NP_ABLE)
                      | (16'(page_flag) << EXP_PAGE_RX)
                      | (16'(lp_an_reg) << EXP_LP_AN_ABLE);
      assign stat_view = 16'(an_done_reg) << BIT_AN_DONE;

      // Read selection for this port
      assign port_rd[p]  = hit_adv  ? adv_view  :
                           hit_lp   ? lp_view   :
                           hit_exp  ? exp_view  :
                           hit_stat ? stat_view : 16'h0000;
      assign port_hit[p] = hit_adv | hit_lp | hit_exp | hit_stat | hit_ctrl;
      assign rd_chain[p+1]  = rd_chain[p] | port_rd[p];
      assign hit_chain[p+1] = hit_chain[p] | port_hit[p];

      // Events toward the interrupt controller
      assign irq_bus.events[2*p]     = i_lcw_valid[p];
      assign irq_bus.events[2*p + 1] = i_pd_fault[p];

      // Outputs toward the negotiation engine
      assign o_restart_an[p]         = restart_reg;
      assign o_adv_word[p*16 +: 16]  = adv_view;
    end
  endgenerate

  // Interrupt register writes
  assign irq_bus.wr_stat = i_wr & hit_irq_stat;
  assign irq_bus.wr_mask = i_wr & hit_irq_mask;
  assign irq_bus.wdata   = i_wdata[IRQ_W-1:0];

  par_irq_ctrl u_irq (
    .i_sys_clk (i_sys_clk),
    .i_srst    (i_srst),
    .bus       (irq_bus)
  );

  // Read data source; unmapped and control reads return zero
  logic [15:0] rdata_sel;
  logic [15:0] rdata_next;
  assign rdata_sel  = hit_irq_stat ? {6'h00, irq_bus.stat} :
                      hit_irq_mask ? {6'h00, irq_bus.mask} :
                      rd_chain[NPORT];
  assign rdata_next = i_rd ? rdata_sel : 16'h0000;

  // Read data stands only in the cycle after the strobe
  logic [15:0] rdata_reg;
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_irq   = irq_bus.irq;
endmodule
`default_nettype wire

// [dv/par_partner.sv]
// Link partner model driving code words and line status
`timescale 1ns/1ns
`default_nettype none
module par_partner (
  input  wire logic  i_sys_clk,
  output logic [4:0]  o_lcw_valid,
  output logic [79:0] o_lcw_data,
  output logic [4:0]  o_lp_an_able,
  output logic [4:0]  o_pd_fault,
  output logic [4:0]  o_an_done
);
  // Quiet line at time zero
  initial begin
    o_lcw_valid = 5'h00;
    o_lcw_data = 80'h0;
    o_lp_an_able = 5'h00;
    o_pd_fault = 5'h00;
    o_an_done = 5'h00;
  end
  // One-cycle code word, then the stale word shows inverted
  task automatic send_page(input int p, input logic [15:0] w);
    @(posedge i_sys_clk);
    o_lcw_valid[p] <= 1'b1;
    o_lcw_data[16*p +: 16] <= w;
    @(posedge i_sys_clk);
    o_lcw_valid[p] <= 1'b0;
    o_lcw_data[16*p +: 16] <= ~w;
  endtask
  // Line status levels
  task automatic set_line(input logic [4:0] able, input logic [4:0] pd, input logic [4:0] dn);
    @(posedge i_sys_clk);
    o_lp_an_able <= able;
    o_pd_fault <= pd;
    o_an_done <= dn;
  endtask
endmodule
`default_nettype wire

// [dv/par_ability_regs_sva.sv]
// Port checks of the ability register bank
`timescale 1ns/1ns
`default_nettype none
module par_ability_regs_sva (
  input wire logic        i_sys_clk,
  input wire logic        i_srst,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [4:0]  i_lcw_valid,
  input wire logic [79:0] i_lcw_data,
  input wire logic [4:0]  i_lp_an_able,
  input wire logic [4:0]  i_pd_fault,
  input wire logic [15:0] o_rdata,
  input wire logic        o_irq,
  input wire logic [4:0]  o_restart_an,
  input wire logic [79:0] o_adv_word
);
  // Port 1 read decodes
  wire logic rd_adv = i_rd && (i_addr == 16'h1108);
  wire logic rd_par = i_rd && (i_addr == 16'h110a);
  wire logic rd_exp = i_rd && (i_addr == 16'h110c);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data not idle");
  adv_t4_a: assert property ((o_adv_word & {5{16'h0200}}) == 80'h0)
    else $error("T4 bit advertised");
  adv_read_a: assert property (rd_adv |=> o_rdata == $past(o_adv_word[15:0]))
    else $error("advert read differs");
  exp_fixed_a: assert property (rd_exp |=> o_rdata[2] && o_rdata[15:5] == 11'h000)
    else $error("expansion fixed bits wrong");
  partner_word_a: assert property (i_lcw_valid[0] ##1 !i_lcw_valid[0] ##1 rd_par
    |=> o_rdata == (($past(i_lcw_data[15:0], 3) & 16'hafff) | 16'h4000)) else $error("bad word");
  lp_able_a: assert property (rd_exp && $stable(i_lp_an_able[0])
    |=> o_rdata[0] == $past(i_lp_an_able[0])) else $error("partner able bit wrong");
  pd_latch_a: assert property (i_pd_fault[0] ##1 rd_exp |=> o_rdata[4])
    else $error("fault flag not latched");
  lh_clear_a: assert property ((rd_exp && !i_pd_fault[0] && !i_lcw_valid[0])
    ##1 (!i_pd_fault[0] && !i_lcw_valid[0]) ##1 rd_exp |=> !o_rdata[4] && !o_rdata[1])
    else $error("latched flag not cleared");
  irq_cause_a: assert property ($rose(o_irq) |-> $past(|i_lcw_valid || |i_pd_fault || i_wr, 2))
    else $error("interrupt without cause");
  restart_a: assert property (i_wr && i_addr == 16'h1100 && i_wdata[9]
    |=> o_restart_an == 5'h01) else $error("restart pulse missing");
  // Main scenarios
  cover property (rd_par ##1 o_rdata[14]);
  cover property (o_irq);
  cover property (o_restart_an[0]);
endmodule
bind par_ability_regs par_ability_regs_sva par_ability_regs_sva_i (.i_sys_clk, .i_srst,
  .i_addr, .i_wdata, .i_wr, .i_rd, .i_lcw_valid, .i_lcw_data, .i_lp_an_able, .i_pd_fault,
  .o_rdata, .o_irq, .o_restart_an, .o_adv_word);
`default_nettype wire

// [dv/par_ability_regs_tb.sv]
// Self-checking bench of the ability register bank
`timescale 1ns/1ns
`default_nettype none
module par_ability_regs_tb;
  import par_pkg::*;
  logic                     i_sys_clk, i_srst, i_wr, i_rd;
  logic [15:0]              i_addr, i_wdata;
  wire logic [NPORT-1:0]    lcw_valid, lp_able, pd_fault, an_done, o_restart_an;
  wire logic [NPORT*16-1:0] lcw_data, o_adv_word;
  wire logic [15:0]         o_rdata;
  wire logic                o_irq;
  int                       err_count = 0, num_checks = 0, cyc = 0;
  par_ability_regs par_ability_regs_i (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_lcw_valid(lcw_valid),
    .i_lcw_data(lcw_data), .i_lp_an_able(lp_able), .i_pd_fault(pd_fault),
    .i_an_done(an_done), .o_rdata(o_rdata), .o_irq(o_irq), .o_restart_an(o_restart_an),
    .o_adv_word(o_adv_word));
  par_partner par_partner_i (.i_sys_clk(i_sys_clk), .o_lcw_valid(lcw_valid),
    .o_lcw_data(lcw_data), .o_lp_an_able(lp_able), .o_pd_fault(pd_fault), .o_an_done(an_done));
  // Clock and hang guard
  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bus cycles: one strobe cycle, read data checked in the cycle after
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e);
  endtask
  task automatic t_reset;
    for (int p = 1; p <= 5; p++) rd({4'(p), 12'h108}, ADVERT_RESET);
    rd(16'h110a, 16'h0000);
    rd(16'h110c, 16'h0004);
    rd(16'h1102, 16'h0000);
  endtask
  task automatic t_advert;
    wr(16'h1108, 16'hffff);
    rd(16'h1108, 16'hadff);
    wr(16'h1108, 16'h0000);
    rd(16'h1108, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      wr(16'h2108, {4'h0, 2'(c), 10'h001});
      rd(16'h2108, {4'h0, 2'(c), 10'h001});
      chk(o_adv_word[31:16], {4'h0, 2'(c), 10'h001});
    end
    wr(16'h110a, 16'hffff);
    rd(16'h110a, 16'h0000);
  endtask
  task automatic t_page;
    par_partner_i.set_line(5'h01, 5'h00, 5'h01);
    wr(16'h0f02, 16'h0001);
    par_partner_i.send_page(0, 16'hffff);
    rd(16'h110a, 16'hefff);
    rd(16'h110c, 16'h000f);
    rd(16'h110c, 16'h000d);
    chk({15'h0, o_irq}, 16'h0001);
    rd(16'h0f00, 16'h0001);
    wr(16'h0f00, 16'h0001);
    repeat (2) @(posedge i_sys_clk);
    #1 chk({15'h0, o_irq}, 16'h0000);
    rd(16'h1102, 16'h0020);
    wr(16'h0f02, 16'h0000);
    par_partner_i.send_page(0, 16'h0001);
    rd(16'h110a, 16'h4001);
    rd(16'h110c, 16'h0007);
    chk({15'h0, o_irq}, 16'h0000);
  endtask
  task automatic t_fault;
    par_partner_i.set_line(5'h01, 5'h01, 5'h01);
    rd(16'h110c, 16'h0015);
    rd(16'h110c, 16'h0015);
    par_partner_i.set_line(5'h01, 5'h00, 5'h01);
    rd(16'h110c, 16'h0015);
    rd(16'h110c, 16'h0005);
    rd(16'h0f00, 16'h0003);
    wr(16'h0f00, 16'h0003);
    rd(16'h0f00, 16'h0000);
  endtask
  task automatic t_restart;
    wr(16'h1100, 16'h0200);
    #1 chk({11'h0, o_restart_an}, 16'h0001);
    rd(16'h110a, 16'h0001);
    rd(16'h1100, 16'h0000);
    rd(16'h1200, 16'h0000);
  endtask
  // Reset, then scenarios in turn
  initial begin
    i_srst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 16'h0000;
    i_wdata = 16'h0000;
    repeat (6) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    t_reset();
    t_advert();
    t_page();
    t_fault();
    t_restart();
    give_verdict();
  end
endmodule
`default_nettype wire
